// file: src/rpm_pkg.sv
// Purpose: Shared constants for the radio packet mode configuration block
// Assumes: 25 MHz controller clock, byte wide register port
// Notes:   Offsets, field positions, reset values and timing counts
package rpm_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [9:0] RPM_ADDR_EXT_SWITCH  = 10'h100;
    localparam logic [9:0] RPM_ADDR_PREAMBLE    = 10'h102;
    localparam logic [9:0] RPM_ADDR_CCA_THRES   = 10'h105;
    localparam logic [9:0] RPM_ADDR_CCA_CTRL    = 10'h106;
    localparam logic [9:0] RPM_ADDR_FRAME_STORE = 10'h107;
    localparam logic [9:0] RPM_ADDR_TX_DELAY    = 10'h10a;
    localparam logic [9:0] RPM_ADDR_STATUS      = 10'h1f0;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int RPM_AMP_OFF_STYLE_BIT = 7;
    localparam int RPM_RX_PIN_AUTO_BIT   = 4;
    localparam int RPM_TX_PIN_AUTO_BIT   = 3;
    localparam int RPM_AMP_AUTO_BIT      = 2;
    localparam int RPM_CCA_CONT_BIT      = 2;
    localparam int RPM_CCA_AUTO_BIT      = 1;
    localparam int RPM_DELAY_OFF_BIT     = 7;
    localparam int RPM_TX_MODE_LSB       = 4;
    localparam int RPM_SEND_LISTEN_BIT   = 3;
    localparam int RPM_LISTEN_SEND_BIT   = 2;
    localparam int RPM_RX_MODE_LSB       = 0;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] RPM_RST_EXT_SWITCH  = 8'h00;
    localparam logic [7:0] RPM_RST_PREAMBLE    = 8'h08;
    localparam logic [7:0] RPM_RST_CCA_THRES   = 8'hab;
    localparam logic [7:0] RPM_RST_CCA_CTRL    = 8'h00;
    localparam logic [7:0] RPM_RST_FRAME_STORE = 8'h00;
    localparam logic [7:0] RPM_RST_TX_DELAY    = 8'hc0;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int RPM_CLK_PERIOD_NS = 40;
    localparam int RPM_US_NS         = 1000;
    localparam int RPM_US_CYCLES     = RPM_US_NS / RPM_CLK_PERIOD_NS;
    localparam int RPM_CCA_PERIOD_US = 128;

    // ------------------------------------------------------------------
    // Store modes and controller states
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        RPM_TXM_ONCE      = 2'b00,
        RPM_TXM_CYC_RAMP  = 2'b01,
        RPM_TXM_RESERVED  = 2'b10,
        RPM_TXM_CYC_HOLD  = 2'b11
    } rpm_tx_mode_t;

    typedef enum logic [1:0] {
        RPM_RXM_FIRST     = 2'b00,
        RPM_RXM_CONT      = 2'b01,
        RPM_RXM_NO_STORE  = 2'b10,
        RPM_RXM_RESERVED  = 2'b11
    } rpm_rx_mode_t;

    typedef enum logic [1:0] {
        RPM_ST_IDLE    = 2'b00,
        RPM_ST_TX_WAIT = 2'b01,
        RPM_ST_TX      = 2'b10,
        RPM_ST_RX      = 2'b11
    } rpm_state_t;

endpackage : rpm_pkg

// file: src/rpm_radio_ctrl.sv
// Purpose: Packet mode configuration registers and front-end pin control
// Assumes: Command and frame-done strobes come from logic on clk_in
// Notes:   State walks ready, transmit wait, transmit and receive
//
// The implementer's own choice: strobed register access.
module rpm_radio_ctrl
    import rpm_pkg::*;
#(
    parameter int US_CYCLES = RPM_US_CYCLES
) (
    input  wire logic       clk_in,
    input  wire logic       sys_rst_in,
    input  wire logic [9:0] reg_addr_in,
    input  wire logic [7:0] reg_wdata_in,
    input  wire logic       reg_wr_in,
    input  wire logic       reg_rd_in,
    output logic      [7:0] reg_rdata_out,
    input  wire logic       transmit_command_in,
    input  wire logic       receive_command_in,
    input  wire logic       tx_frame_sent_in,
    input  wire logic       rx_frame_received_in,
    input  wire logic [7:0] rssi_readback_in,
    input  wire logic [7:0] preamble_extra_in,
    input  wire logic       general_pin_output_rx_in,
    input  wire logic       general_pin_output_tx_in,
    input  wire logic       aux_power_control_bias_in,
    output logic            rx_switch_pin_out,
    output logic            tx_switch_pin_out,
    output logic            ext_amp_enable_out,
    output logic            amp_off_style_out,
    output logic            amp_hold_on_out,
    output logic      [8:0] preamble_total_out,
    output logic            tx_frame_start_out,
    output logic            rx_store_write_out,
    output logic            cca_event_out,
    output logic            cca_clear_out,
    output logic      [1:0] radio_state_out
);

    localparam int DW = (US_CYCLES > 1) ? $clog2(US_CYCLES) : 1;
    localparam logic [DW-1:0] DIV_LAST = DW'(US_CYCLES - 1);
    localparam logic [6:0] CCA_LAST = 7'(RPM_CCA_PERIOD_US - 1);

    // Refuse a microsecond divider that cannot count
    if (US_CYCLES < 2) begin : g_chk
        $error("US_CYCLES must be at least 2");
    end

    // ------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------
    logic [7:0] ext_switch_q;
    logic [7:0] preamble_q;
    logic [7:0] cca_thres_q;
    logic [7:0] cca_ctrl_q;
    logic [7:0] frame_store_q;
    logic [7:0] tx_delay_q;

    wire sel_ext   = (reg_addr_in == RPM_ADDR_EXT_SWITCH);
    wire sel_pre   = (reg_addr_in == RPM_ADDR_PREAMBLE);
    wire sel_thr   = (reg_addr_in == RPM_ADDR_CCA_THRES);
    wire sel_cca   = (reg_addr_in == RPM_ADDR_CCA_CTRL);
    wire sel_store = (reg_addr_in == RPM_ADDR_FRAME_STORE);
    wire sel_dly   = (reg_addr_in == RPM_ADDR_TX_DELAY);

    // Register writes; reserved bits are stored as written
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            ext_switch_q  <= RPM_RST_EXT_SWITCH;
            preamble_q    <= RPM_RST_PREAMBLE;
            cca_thres_q   <= RPM_RST_CCA_THRES;
            cca_ctrl_q    <= RPM_RST_CCA_CTRL;
            frame_store_q <= RPM_RST_FRAME_STORE;
            tx_delay_q    <= RPM_RST_TX_DELAY;
        end else if (reg_wr_in) begin
            if (sel_ext)   ext_switch_q  <= reg_wdata_in;
            if (sel_pre)   preamble_q    <= reg_wdata_in;
            if (sel_thr)   cca_thres_q   <= reg_wdata_in;
            if (sel_cca)   cca_ctrl_q    <= reg_wdata_in;
            if (sel_store) frame_store_q <= reg_wdata_in;
            if (sel_dly)   tx_delay_q    <= reg_wdata_in;
        end
    end

    // Field views
    wire rx_pin_auto  = ext_switch_q[RPM_RX_PIN_AUTO_BIT];
    wire tx_pin_auto  = ext_switch_q[RPM_TX_PIN_AUTO_BIT];
    wire amp_auto     = ext_switch_q[RPM_AMP_AUTO_BIT];
    wire cca_cont     = cca_ctrl_q[RPM_CCA_CONT_BIT];
    wire cca_auto     = cca_ctrl_q[RPM_CCA_AUTO_BIT];
    wire delay_off    = frame_store_q[RPM_DELAY_OFF_BIT];
    wire send_listen  = frame_store_q[RPM_SEND_LISTEN_BIT];
    wire listen_send  = frame_store_q[RPM_LISTEN_SEND_BIT];
    rpm_tx_mode_t tx_mode;
    rpm_rx_mode_t rx_mode;
    assign tx_mode = rpm_tx_mode_t'(frame_store_q[RPM_TX_MODE_LSB +: 2]);
    assign rx_mode = rpm_rx_mode_t'(frame_store_q[RPM_RX_MODE_LSB +: 2]);

    // ------------------------------------------------------------------
    // Microsecond tick
    // ------------------------------------------------------------------
    logic [DW-1:0] div_q;
    wire           us_tick = (div_q == DIV_LAST);

    // Free running divider, one pulse per microsecond
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            div_q <= '0;
        end else begin
            div_q <= us_tick ? '0 : div_q + 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Controller state machine
    // ------------------------------------------------------------------
    rpm_state_t state_q;
    rpm_state_t state_d;
    logic [7:0] dly_q;
    logic       cyc_q;
    logic       cyc_d;
    logic       load_dly;

    wire cyclic_tx = (tx_mode == RPM_TXM_CYC_RAMP) ||
                     (tx_mode == RPM_TXM_CYC_HOLD);
    wire rx_stays  = (rx_mode == RPM_RXM_CONT) ||
                     (rx_mode == RPM_RXM_NO_STORE);
    wire dly_done  = (dly_q == 8'h00);

    // Next state; a transmit start goes through the MAC delay unless off
    always_comb begin
        state_d  = state_q;
        cyc_d    = cyc_q;
        load_dly = 1'b0;
        case (state_q)
            RPM_ST_IDLE: begin
                cyc_d = 1'b0;
                if (transmit_command_in) begin
                    state_d  = delay_off ? RPM_ST_TX : RPM_ST_TX_WAIT;
                    load_dly = 1'b1;
                end else if (receive_command_in) begin
                    state_d = RPM_ST_RX;
                end
            end
            RPM_ST_TX_WAIT: begin
                if (dly_done) begin
                    state_d = RPM_ST_TX;
                end
            end
            RPM_ST_TX: begin
                if (tx_frame_sent_in) begin
                    if (send_listen) begin
                        state_d = RPM_ST_RX;
                        cyc_d   = 1'b0;
                    end else if (cyclic_tx) begin
                        state_d  = delay_off ? RPM_ST_TX
                                             : RPM_ST_TX_WAIT;
                        load_dly = 1'b1;
                        cyc_d    = 1'b1;
                    end else begin
                        state_d = RPM_ST_IDLE;
                        cyc_d   = 1'b0;
                    end
                end
            end
            RPM_ST_RX: begin
                if (rx_frame_received_in) begin
                    if (listen_send) begin
                        state_d  = delay_off ? RPM_ST_TX
                                             : RPM_ST_TX_WAIT;
                        load_dly = 1'b1;
                    end else if (!rx_stays) begin
                        state_d = RPM_ST_IDLE;
                    end
                end
            end
            default: begin
                state_d = RPM_ST_IDLE;
            end
        endcase
    end

    // State and cyclic flag
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state_q <= RPM_ST_IDLE;
            cyc_q   <= 1'b0;
        end else begin
            state_q <= state_d;
            cyc_q   <= cyc_d;
        end
    end

    // MAC delay countdown in microseconds
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            dly_q <= 8'h00;
        end else if (load_dly) begin
            dly_q <= tx_delay_q;
        end else if (us_tick && !dly_done) begin
            dly_q <= dly_q - 8'h01;
        end
    end

    // ------------------------------------------------------------------
    // Channel assessment timing
    // ------------------------------------------------------------------
    logic [6:0] cont_us_q;
    logic [6:0] auto_us_q;
    logic       auto_arm_q;

    wire rx_entry  = (state_d == RPM_ST_RX) && (state_q != RPM_ST_RX);
    wire cont_fire = cca_cont && us_tick && (cont_us_q == CCA_LAST);
    wire auto_fire = auto_arm_q && us_tick && (auto_us_q == CCA_LAST);
    wire cca_fire  = cont_fire || auto_fire;
    wire rssi_low  = $signed(rssi_readback_in) < $signed(cca_thres_q);

    // Periodic counter runs only while continuous assessment is on
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cont_us_q <= 7'h00;
        end else if (!cca_cont) begin
            cont_us_q <= 7'h00;
        end else if (us_tick) begin
            cont_us_q <= cont_us_q + 7'h01;
        end
    end

    // One-shot counter armed on entry to receive
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            auto_us_q  <= 7'h00;
            auto_arm_q <= 1'b0;
        end else if (rx_entry) begin
            auto_us_q  <= 7'h00;
            auto_arm_q <= cca_auto;
        end else if (auto_fire || !cca_auto) begin
            auto_arm_q <= 1'b0;
        end else if (auto_arm_q && us_tick) begin
            auto_us_q <= auto_us_q + 7'h01;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    wire tx_next  = (state_d == RPM_ST_TX);
    wire rx_next  = (state_d == RPM_ST_RX);
    wire hold_amp = (tx_mode == RPM_TXM_CYC_HOLD) && cyc_d &&
                    (state_d == RPM_ST_TX_WAIT);
    wire store_ok = (rx_mode == RPM_RXM_FIRST) || (rx_mode == RPM_RXM_CONT);

    // Front-end pins follow the next state so they match state_q
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            rx_switch_pin_out  <= 1'b0;
            tx_switch_pin_out  <= 1'b0;
            ext_amp_enable_out <= 1'b0;
            amp_hold_on_out    <= 1'b0;
        end else begin
            rx_switch_pin_out  <= rx_pin_auto ? rx_next
                                : general_pin_output_rx_in;
            tx_switch_pin_out  <= tx_pin_auto ? tx_next
                                : general_pin_output_tx_in;
            ext_amp_enable_out <= amp_auto ? (tx_next || hold_amp)
                                : aux_power_control_bias_in;
            amp_hold_on_out    <= hold_amp;
        end
    end

    // Static settings and frame events
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            amp_off_style_out  <= 1'b0;
            preamble_total_out <= 9'h000;
            tx_frame_start_out <= 1'b0;
            rx_store_write_out <= 1'b0;
            radio_state_out    <= 2'b00;
        end else begin
            amp_off_style_out  <= ext_switch_q[RPM_AMP_OFF_STYLE_BIT];
            preamble_total_out <= {1'b0, preamble_q} +
                                  {1'b0, preamble_extra_in};
            tx_frame_start_out <= tx_next && (state_q != RPM_ST_TX ||
                                  tx_frame_sent_in);
            rx_store_write_out <= (state_q == RPM_ST_RX) &&
                                  rx_frame_received_in && store_ok;
            radio_state_out    <= state_d;
        end
    end

    // Assessment event and result
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cca_event_out <= 1'b0;
            cca_clear_out <= 1'b0;
        end else begin
            cca_event_out <= cca_fire;
            if (cca_fire) begin
                cca_clear_out <= rssi_low;
            end
        end
    end

    // ------------------------------------------------------------------
    // Register read, one cycle after the strobe
    // ------------------------------------------------------------------
    logic [7:0] rd_mux;

    // Reserved fields read back as stored
    always_comb begin
        if (sel_ext) begin
            rd_mux = ext_switch_q;
        end else if (sel_pre) begin
            rd_mux = preamble_q;
        end else if (sel_thr) begin
            rd_mux = cca_thres_q;
        end else if (sel_cca) begin
            rd_mux = cca_ctrl_q;
        end else if (sel_store) begin
            rd_mux = frame_store_q;
        end else if (sel_dly) begin
            rd_mux = tx_delay_q;
        end else if (reg_addr_in == RPM_ADDR_STATUS) begin
            rd_mux = {5'h00, cca_clear_out, radio_state_out};
        end else begin
            rd_mux = 8'h00;
        end
    end

    // Read data stand only in the cycle after the strobe
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            reg_rdata_out <= 8'h00;
        end else begin
            reg_rdata_out <= reg_rd_in ? rd_mux : 8'h00;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_rx_pin_auto: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        rx_pin_auto |=> (rx_switch_pin_out == (state_q == RPM_ST_RX)))
        else $error("receive pin does not track receive state");

    a_tx_pin_auto: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        tx_pin_auto |=> (tx_switch_pin_out == (state_q == RPM_ST_TX)))
        else $error("transmit pin does not track transmit state");

    a_amp_manual: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        !amp_auto |=> (ext_amp_enable_out == $past(aux_power_control_bias_in)))
        else $error("external amplifier ignores software bias");

    a_cca_result: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        cca_fire |=> cca_event_out && (cca_clear_out ==
            ($signed($past(rssi_readback_in)) < $signed($past(cca_thres_q)))))
        else $error("assessment result wrong");

    a_tx_once_idle: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (state_q == RPM_ST_TX && tx_frame_sent_in && !send_listen &&
         tx_mode == RPM_TXM_ONCE) |=> state_q == RPM_ST_IDLE)
        else $error("single transmit did not return to ready");

    a_send_listen: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (state_q == RPM_ST_TX && tx_frame_sent_in && send_listen)
        |=> state_q == RPM_ST_RX ##0 (rx_switch_pin_out || !rx_pin_auto))
        else $error("turnaround to receive missing");

    a_rx_no_store: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (rx_mode == RPM_RXM_NO_STORE) |=> !rx_store_write_out)
        else $error("store written while storing is off");

    a_rx_cont_stay: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (state_q == RPM_ST_RX && rx_frame_received_in && !listen_send &&
         rx_mode == RPM_RXM_CONT) |=> state_q == RPM_ST_RX ##0 rx_store_write_out)
        else $error("continuous receive left receive state");

    a_delay_skip: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (state_q == RPM_ST_IDLE && transmit_command_in && delay_off)
        |=> state_q == RPM_ST_TX ##0 tx_frame_start_out)
        else $error("disabled delay still waited");

endmodule : rpm_radio_ctrl

// file: testbench/tb.sv
// Purpose: Self-checking bench for the packet mode configuration block
// Assumes: Microsecond shortened to two clocks through US_CYCLES
// Notes:   Read results are matched against a queue by a monitor process
module tb import rpm_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int US = 2;
    logic        clk_in = 1'b0, sys_rst_in = 1'b1, reg_wr_in = 1'b0;
    logic        reg_rd_in = 1'b0, rd_d = 1'b0;
    logic [9:0]  addr = '0;
    logic [7:0]  wdata = '0, rssi = '0, extra = '0, rdata;
    logic [3:0]  ev = '0;
    logic [2:0]  gp = '0;
    logic [31:0] rnd = 32'h0000_6d1f;
    logic        rx_pin, tx_pin, amp_en, off_style, hold, start, store;
    logic        cca_ev, cca_clr;
    logic [8:0]  pre_tot;
    logic [1:0]  state;
    logic [7:0]  exp_q[$];
    int          miscompares = 0, checks = 0, n;

    rpm_radio_ctrl #(.US_CYCLES(US)) u_rpm_radio_ctrl (
        .clk_in(clk_in), .sys_rst_in(sys_rst_in), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_rdata_out(rdata), .transmit_command_in(ev[0]),
        .receive_command_in(ev[1]), .tx_frame_sent_in(ev[2]),
        .rx_frame_received_in(ev[3]), .rssi_readback_in(rssi),
        .preamble_extra_in(extra), .general_pin_output_rx_in(gp[2]),
        .general_pin_output_tx_in(gp[1]), .aux_power_control_bias_in(gp[0]),
        .rx_switch_pin_out(rx_pin), .tx_switch_pin_out(tx_pin),
        .ext_amp_enable_out(amp_en), .amp_off_style_out(off_style),
        .amp_hold_on_out(hold), .preamble_total_out(pre_tot),
        .tx_frame_start_out(start), .rx_store_write_out(store),
        .cca_event_out(cca_ev), .cca_clear_out(cca_clr),
        .radio_state_out(state));

    // 25 MHz clock
    always #20 clk_in = ~clk_in;

    // Read data stand in the cycle after the read strobe
    always @(posedge clk_in) begin
        if (rd_d)
            check({1'b0, rdata}, {1'b0, exp_q.pop_front()});
        rd_d = reg_rd_in;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %0t ns: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr <= a;
        wdata <= d;
        reg_wr_in <= 1'b1;
        @(posedge clk_in);
        reg_wr_in <= 1'b0;
    endtask

    task automatic rd(input logic [9:0] a, input logic [7:0] e);
        @(posedge clk_in);
        addr <= a;
        reg_rd_in <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk_in);
        reg_rd_in <= 1'b0;
    endtask

    // One-cycle event pulse; returns just after the edge that took it
    task automatic pulse(input int i);
        @(posedge clk_in);
        ev[i] <= 1'b1;
        @(posedge clk_in);
        ev[i] <= 1'b0;
        #1;
    endtask

    // Counts cycles until transmit state (sel 0) or an assessment event
    task automatic wait_for(input int sel, input int lo, input int hi);
        n = 0;
        while (!((sel == 0) ? state === 2'b10 : cca_ev === 1'b1) && n <= hi) begin
            @(posedge clk_in);
            #1;
            n++;
        end
        check({8'h00, n >= lo && n <= hi}, 9'h001);
    endtask

    task automatic done(input string s);
        $display("test %s finished", s);
    endtask

    task automatic end_of_test();
        $display("comparisons %0d, mismatches %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Watchdog, well beyond the expected run length
    initial begin
        #(40 * 20000);
        $display("[FAIL] %0t ns: watchdog expired", $time);
        miscompares++;
        end_of_test();
    end

    initial begin
        repeat (5) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        rd(RPM_ADDR_EXT_SWITCH, 8'h00);
        rd(RPM_ADDR_PREAMBLE, 8'h08);
        rd(RPM_ADDR_CCA_THRES, 8'hab);
        rd(RPM_ADDR_CCA_CTRL, 8'h00);
        rd(RPM_ADDR_FRAME_STORE, 8'h00);
        rd(RPM_ADDR_TX_DELAY, 8'd192);
        rd(10'h1ff, 8'h00);
        for (int i = 0; i < 4; i++) begin
            rnd = lfsr(rnd);
            wr(RPM_ADDR_PREAMBLE, rnd[7:0]);
            rd(RPM_ADDR_PREAMBLE, rnd[7:0]);
            extra <= rnd[15:8];
            repeat (3) @(posedge clk_in);
            #1;
            check(pre_tot, {1'b0, rnd[7:0]} + {1'b0, rnd[15:8]});
        end
        done("registers");
        gp <= 3'b101;
        repeat (3) @(posedge clk_in);
        #1;
        check({rx_pin, tx_pin, amp_en}, 9'h005);
        wr(RPM_ADDR_EXT_SWITCH, 8'h9c);
        wr(RPM_ADDR_FRAME_STORE, 8'h80);
        repeat (2) @(posedge clk_in);
        #1;
        check({off_style, rx_pin, tx_pin, amp_en}, 9'h008);
        pulse(0);
        check({state, tx_pin, rx_pin, amp_en, start}, 9'h02b);
        pulse(2);
        check({state, tx_pin, amp_en}, 9'h000);
        wr(RPM_ADDR_FRAME_STORE, 8'h88);
        pulse(0);
        pulse(2);
        check({state, rx_pin, tx_pin}, 9'h00e);
        pulse(3);
        check({state, store}, 9'h001);
        done("turnaround");
        for (int m = 1; m < 3; m++) begin
            wr(RPM_ADDR_FRAME_STORE, 8'h80 | 8'(m));
            pulse(1);
            pulse(3);
            check({state, store}, {6'h00, 2'b11, m == 1});
        end
        wr(RPM_ADDR_FRAME_STORE, 8'h84);
        pulse(3);
        check({7'h00, state}, 9'h002);
        pulse(2);
        wr(RPM_ADDR_TX_DELAY, 8'd4);
        wr(RPM_ADDR_FRAME_STORE, 8'h00);
        pulse(0);
        check({7'h00, state}, 9'h001);
        wait_for(0, 4 * US - 1, 6 * US + 2);
        pulse(2);
        wr(RPM_ADDR_FRAME_STORE, 8'h30);
        pulse(0);
        wait_for(0, 4 * US - 1, 6 * US + 2);
        pulse(2);
        check({5'h00, state, hold, amp_en}, 9'h007);
        wr(RPM_ADDR_FRAME_STORE, 8'h00);
        wait_for(0, 1, 6 * US + 2);
        pulse(2);
        check({7'h00, state}, 9'h000);
        done("store modes");
        for (int i = 0; i < 3; i++) begin
            rnd = lfsr(rnd);
            rssi <= (i == 0) ? rnd[15:8] : rnd[7:0];
            wr(RPM_ADDR_CCA_THRES, rnd[15:8]);
            wr(RPM_ADDR_CCA_CTRL, 8'h04);
            wait_for(1, 128 * US - 6, 128 * US + 6);
            @(posedge clk_in);
            #1;
            check({8'h00, cca_clr}, {8'h00, $signed(rssi) < $signed(rnd[15:8])});
            wr(RPM_ADDR_CCA_CTRL, 8'h00);
        end
        wr(RPM_ADDR_CCA_CTRL, 8'h02);
        wr(RPM_ADDR_FRAME_STORE, 8'h81);
        pulse(1);
        wait_for(1, 128 * US - 6, 128 * US + 6);
        done("assessment");
        repeat (3) @(posedge clk_in);
        end_of_test();
    end
endmodule // tb
